// file: rtl/ltm_consts.vh
/*
 * Constants for the LIN transceiver mode-control host: timing,
 * state codes and mode codes.
 * Assumes a single 25 MHz clock and is included by bare name.
 */
`ifndef LTM_CONSTS_VH
`define LTM_CONSTS_VH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LTM_CLK_PERIOD_NS   40
// Time EN and TXD are held after EN falls, covering the longest
// mode-select window of the device
`define LTM_MSEL_HOLD_NS    10000
// Least time, so round up to whole cycles
`define LTM_MSEL_CYCLES     ((`LTM_MSEL_HOLD_NS + `LTM_CLK_PERIOD_NS - 1) / `LTM_CLK_PERIOD_NS)
`define LTM_CNT_W           9

// ----------------------------------------------------------------
// Controller states
// ----------------------------------------------------------------
`define LTM_ST_W            3
`define LTM_ST_POWERON      3'h0
`define LTM_ST_STANDBY      3'h1
`define LTM_ST_NORMAL       3'h2
`define LTM_ST_MSEL         3'h3
`define LTM_ST_SLEEP        3'h4

// ----------------------------------------------------------------
// Mode codes shown to the user
// ----------------------------------------------------------------
`define LTM_MODE_POWERON    2'h0
`define LTM_MODE_STANDBY    2'h1
`define LTM_MODE_NORMAL     2'h2
`define LTM_MODE_SLEEP      2'h3

`endif

// file: rtl/ltm_host.v
/*
 * Host-side controller for a LIN transceiver with integrated regulator.
 * Drives the enable and transmit-data pins, reads receive data and
 * supply-good, and tracks the transceiver's operating mode.
 * Assumes all pin inputs are synchronous to MCLK and that the
 * transceiver follows its documented mode sequence.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ltm_consts.vh"

module ltm_host (
	input  wire       MCLK,
	input  wire       NRST,
	input  wire       REQ_NORMAL,
	input  wire       REQ_STANDBY,
	input  wire       REQ_SLEEP,
	input  wire       TX_DATA,
	input  wire       RXD,
	input  wire       SUPPLY_GOOD,
	output reg        TXD,
	output reg        EN,
	output reg  [1:0] MODE,
	output reg        BUSY,
	output reg        RX_DATA,
	output reg        WAKE,
	output reg        SUPPLY_OK
);

	// ------------------------------------------------------------
	// Mode code for each controller state
	// ------------------------------------------------------------
	function [1:0] mode_of;
		input [`LTM_ST_W-1:0] st;
		begin
			case (st)
			`LTM_ST_STANDBY: mode_of = `LTM_MODE_STANDBY;
			`LTM_ST_NORMAL:  mode_of = `LTM_MODE_NORMAL;
			`LTM_ST_MSEL:    mode_of = `LTM_MODE_NORMAL;
			`LTM_ST_SLEEP:   mode_of = `LTM_MODE_SLEEP;
			default:         mode_of = `LTM_MODE_POWERON;
			endcase
		end
	endfunction

	// Hold length in cycles, cut on purpose to the counter width;
	// the count must stay below 2**LTM_CNT_W or the hold shrinks
	localparam [31:0] MSEL_CYC = `LTM_MSEL_CYCLES;
	localparam [`LTM_CNT_W-1:0] MSEL_LOAD =
		MSEL_CYC[`LTM_CNT_W-1:0];

	// ------------------------------------------------------------
	// State and next-state signals
	// ------------------------------------------------------------
	reg [`LTM_ST_W-1:0]  state_reg;
	reg [`LTM_ST_W-1:0]  state_next;
	reg [`LTM_CNT_W-1:0] cnt_reg;
	reg [`LTM_CNT_W-1:0] cnt_next;
	reg                  txd_next;
	reg                  en_next;
	reg                  armed_reg;
	reg                  armed_next;
	wire                 arming;

	// ------------------------------------------------------------
	// Driver arming
	// ------------------------------------------------------------
	// Normal mode counts as busy until the driver has armed, so
	// requests and data checks wait for a settled supply
	assign arming = (state_next == `LTM_ST_NORMAL) &&
	                !(armed_reg && (state_reg == `LTM_ST_NORMAL));

	// ------------------------------------------------------------
	// Mode sequencing
	// ------------------------------------------------------------
	// Next state, pin levels and select-window count
	always @* begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		txd_next   = TXD;
		en_next    = EN;
		armed_next = armed_reg;
		case (state_reg)
		`LTM_ST_POWERON: begin
			// Device moves to standby by itself
			en_next  = 1'b0;
			txd_next = 1'b1;
			if (SUPPLY_GOOD) begin
				state_next = `LTM_ST_STANDBY;
			end
		end
		`LTM_ST_STANDBY: begin
			txd_next = 1'b1;
			if (!SUPPLY_GOOD) begin
				state_next = `LTM_ST_POWERON;
				en_next    = 1'b0;
			end else if (REQ_NORMAL) begin
				// EN raised only with supply good
				en_next    = 1'b1;
				armed_next = 1'b0;
				state_next = `LTM_ST_NORMAL;
			end
		end
		`LTM_ST_NORMAL: begin
			// Recessive until supply-good is back so the driver can
			// arm; after a wake from sleep supply-good lags EN
			// Limitation: if the supply never returns, the host
			// waits here with BUSY high until reset
			if (!armed_reg) begin
				txd_next   = 1'b1;
				armed_next = SUPPLY_GOOD;
			end else begin
				// Passed on as is; a stuck low is cut by the far
				// end's dominant timeout, not here
				txd_next = TX_DATA;
			end
			if (armed_reg && !SUPPLY_GOOD) begin
				en_next    = 1'b0;
				txd_next   = 1'b1;
				state_next = `LTM_ST_POWERON;
			end else if (armed_reg && (REQ_STANDBY || REQ_SLEEP)) begin
				// TXD picks the target; held through window
				en_next    = 1'b0;
				txd_next   = REQ_STANDBY;
				cnt_next   = MSEL_LOAD;
				state_next = `LTM_ST_MSEL;
			end
		end
		`LTM_ST_MSEL: begin
			// Device samples TXD inside this hold
			en_next = 1'b0;
			if (cnt_reg != {`LTM_CNT_W{1'b0}}) begin
				cnt_next = cnt_reg - 1'b1;
			end else begin
				txd_next = 1'b1;
				if (TXD) begin
					state_next = `LTM_ST_STANDBY;
				end else begin
					state_next = `LTM_ST_SLEEP;
				end
			end
		end
		`LTM_ST_SLEEP: begin
			txd_next = 1'b1;
			if (REQ_NORMAL) begin
				// EN raise wakes straight to normal
				en_next    = 1'b1;
				armed_next = 1'b0;
				state_next = `LTM_ST_NORMAL;
			end else if (SUPPLY_GOOD) begin
				// Regulator back without EN: remote wake
				state_next = `LTM_ST_STANDBY;
			end
		end
		default: begin
			en_next    = 1'b0;
			txd_next   = 1'b1;
			state_next = `LTM_ST_POWERON;
		end
		endcase
	end

	// State registers; reset matches device power-on mode
	always @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			state_reg <= `LTM_ST_POWERON;
			cnt_reg   <= {`LTM_CNT_W{1'b0}};
			armed_reg <= 1'b0;
			TXD       <= 1'b1;
			EN        <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			armed_reg <= armed_next;
			TXD       <= txd_next;
			EN        <= en_next;
		end
	end

	// ------------------------------------------------------------
	// User-side status
	// ------------------------------------------------------------
	// Registered so every output comes straight from a flip-flop
	always @(posedge MCLK or negedge NRST) begin
		if (!NRST) begin
			MODE      <= `LTM_MODE_POWERON;
			BUSY      <= 1'b1;
			RX_DATA   <= 1'b1;
			WAKE      <= 1'b0;
			SUPPLY_OK <= 1'b0;
		end else begin
			MODE      <= mode_of(state_next);
			BUSY      <= (state_next == `LTM_ST_MSEL) ||
			             (state_next == `LTM_ST_POWERON) ||
			             arming;
			// Bus level only meaningful in normal mode
			RX_DATA   <= (state_reg == `LTM_ST_NORMAL) ? RXD : 1'b1;
			// Low RXD in standby is the wake flag
			WAKE      <= (state_reg == `LTM_ST_STANDBY) && !RXD;
			SUPPLY_OK <= SUPPLY_GOOD;
		end
	end

endmodule // ltm_host

`default_nettype wire

// file: bench/ltm_host_monitor.sv
/* Assertions on the ltm_host pins.
   Assumes one clock MCLK and reset NRST, active low. */
`timescale 1ns/100ps
`default_nettype none
module ltm_host_monitor (
	input wire logic	MCLK,
	input wire logic	NRST,
	input wire logic	REQ_NORMAL,
	input wire logic	REQ_STANDBY,
	input wire logic	REQ_SLEEP,
	input wire logic	TX_DATA,
	input wire logic	RXD,
	input wire logic	SUPPLY_GOOD,
	input wire logic	TXD,
	input wire logic	EN,
	input wire logic [1:0]	MODE,
	input wire logic	BUSY,
	input wire logic	RX_DATA,
	input wire logic	WAKE,
	input wire logic	SUPPLY_OK
);
	// One domain, so clock and reset are stated once
	default clocking @(posedge MCLK); endclocking
	default disable iff (!NRST);
	// Supply and mode tracking
	a_supply_copy: assert property (
		1 |=> SUPPLY_OK == $past(SUPPLY_GOOD)) else $error("supply copy");
	a_loss_down: assert property (
		!SUPPLY_GOOD && !BUSY && (MODE == 2'h1 || MODE == 2'h2)
		|=> !EN && MODE == 2'h0) else $error("supply loss");
	a_normal_entry: assert property (
		REQ_NORMAL && MODE == 2'h1 && !BUSY && SUPPLY_GOOD
		|=> EN && MODE == 2'h2) else $error("normal entry");
	// Mode select: TXD level picks the target, so it must not wander
	a_sleep_sel: assert property (
		REQ_SLEEP && !REQ_STANDBY && MODE == 2'h2 && !BUSY && SUPPLY_GOOD
		|=> !EN && !TXD && BUSY) else $error("sleep select");
	a_standby_sel: assert property (
		REQ_STANDBY && MODE == 2'h2 && !BUSY && SUPPLY_GOOD
		|=> !EN && TXD && BUSY) else $error("standby select");
	a_window_hold: assert property (
		$fell(EN) && BUSY |=> (!EN && $stable(TXD))[*8])
		else $error("window hold");
	// Data path in normal mode
	a_txd_follow: assert property (
		EN && $past(EN, 2) && MODE == 2'h2 && !BUSY
		|-> TXD == $past(TX_DATA)) else $error("txd follow");
	a_rx_pass: assert property (
		MODE == 2'h2 && !BUSY && $past(MODE) == 2'h2 && !$past(BUSY)
		|-> RX_DATA == $past(RXD)) else $error("rx pass");
endmodule // ltm_host_monitor
bind ltm_host ltm_host_monitor u_ltm_host_monitor (.*);
`default_nettype wire

// file: bench/ltm_dev_model.sv
/* Behavioural model of the transceiver's mode logic and pins.
   Assumes EN and TXD come from the host, synchronous to clk. */
`timescale 1ns/100ps
`default_nettype none
module ltm_dev_model #(
	parameter int SEL = 100
) (
	input wire logic	clk,
	input wire logic	rst_n,
	input wire logic	bat_ok,
	input wire logic	wake,
	input wire logic	en,
	input wire logic	txd,
	output logic	rxd,
	output logic	supply_good
);
	logic [1:0]	mode_reg;
	logic	en_reg;
	int	cnt_reg;
	// Modes 0 power-on, 1 standby, 2 normal, 3 sleep; battery loss wins
	always @(posedge clk or negedge rst_n) begin
		en_reg <= en;
		cnt_reg <= (mode_reg == 2'h2 && !en) ? cnt_reg + 1 : 0;
		if (!rst_n || !bat_ok) begin
			mode_reg <= 2'h0;
		end else if (mode_reg == 2'h0) begin
			mode_reg <= 2'h1;
		end else if (mode_reg[0] && en && !en_reg) begin
			mode_reg <= 2'h2;
		end else if (mode_reg == 2'h3 && wake) begin
			mode_reg <= 2'h1;
		end else if (mode_reg == 2'h2 && !en && cnt_reg == SEL) begin
			mode_reg <= txd ? 2'h1 : 2'h3;
		end
	end
	// Bus loops back in normal; transmit is blocked once EN drops
	assign rxd = (mode_reg == 2'h2) ? (txd | !en)
		: (mode_reg != 2'h1);
	assign supply_good = mode_reg == 2'h1 || mode_reg == 2'h2;
endmodule // ltm_dev_model
`default_nettype wire

// file: bench/ltm_host_tb.sv
/* Self-checking bench for ltm_host with the device model on its pins.
   Assumes the design, checker and model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
	fail_count++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module ltm_host_tb;
	logic	MCLK = 0, NRST = 0, REQ_NORMAL = 0, REQ_STANDBY = 0;
	logic	REQ_SLEEP = 0, TX_DATA = 1, bat_ok = 0, wake = 0;
	logic	RXD, SUPPLY_GOOD, TXD, EN, BUSY, RX_DATA, WAKE, SUPPLY_OK;
	logic [1:0]	MODE;
	int	fail_count = 0, comparisons = 0, cyc = 0;
	always #20 MCLK = ~MCLK;
	ltm_host u_ltm_host (.*);
	ltm_dev_model u_ltm_dev_model (.clk(MCLK), .rst_n(NRST),
		.bat_ok(bat_ok), .wake(wake), .en(EN), .txd(TXD), .rxd(RXD),
		.supply_good(SUPPLY_GOOD));
	// Inputs move 1 ns after the edge so no race with the design
	task tick(input int n);
		repeat (n) @(posedge MCLK);
		#1;
	endtask
	task req(input logic [2:0] r);
		{REQ_NORMAL, REQ_STANDBY, REQ_SLEEP} = r;
		tick(1);
		{REQ_NORMAL, REQ_STANDBY, REQ_SLEEP} = 3'h0;
	endtask
	// Bounded wait for a settled mode
	task wait_mode(input logic [1:0] m);
		for (int i = 0; i < 400 && (MODE !== m || BUSY !== 1'b0); i++)
			tick(1);
		`CHK("MODE", m, MODE)
	endtask
	task t_power;
		tick(5);
		`CHK("BUSY", 1'b1, BUSY)
		bat_ok = 1;
		wait_mode(2'h1);
		tick(2);
		`CHK("WAKE", 1'b1, WAKE)
		$display("t_power done");
	endtask
	task t_normal;
		req(3'h4);
		`CHK("EN", 1'b1, EN)
		TX_DATA = 0;
		tick(4);
		`CHK("TXD", 1'b0, TXD)
		`CHK("RX_DATA", 1'b0, RX_DATA)
		TX_DATA = 1;
		tick(3);
		$display("t_normal done");
	endtask
	task t_select(input logic [2:0] r, input logic [1:0] m);
		req(r);
		tick(1);
		`CHK("EN", 1'b0, EN)
		wait_mode(m);
		`CHK("SUPPLY_OK", m == 2'h1, SUPPLY_OK)
		$display("t_select done");
	endtask
	task t_sleep_normal;
		req(3'h4);
		`CHK("EN", 1'b1, EN)
		wait_mode(2'h2);
		`CHK("TXD", 1'b1, TXD)
		$display("t_sleep_normal done");
	endtask
	task t_wake_loss;
		wake = 1;
		tick(1);
		wake = 0;
		wait_mode(2'h1);
		t_normal;
		bat_ok = 0;
		tick(3);
		`CHK("MODE", 2'h0, MODE)
		$display("t_wake_loss done");
	endtask
	task give_verdict;
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Hang guard, well above the roughly 1100 cycles needed
	always @(posedge MCLK) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			give_verdict;
		end
	end
	initial begin
		tick(20);
		NRST = 1;
		t_power;
		t_normal;
		t_select(3'h2, 2'h1);
		t_normal;
		t_select(3'h3, 2'h1);
		t_normal;
		t_select(3'h1, 2'h3);
		t_sleep_normal;
		t_select(3'h1, 2'h3);
		t_wake_loss;
		give_verdict;
	end
endmodule // ltm_host_tb
`default_nettype wire
